// ==== include/oscpm_pkg.sv ====
// Constants, register map and types for the oscillator power mode controller
package oscpm_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADR_BAND = 32'h0004_0300;
  localparam logic [31:0] ADR_TRIM = 32'h0004_0304;
  localparam logic [31:0] ADR_CTRL = 32'h0004_0308;
  localparam logic [31:0] ADR_STAT = 32'h0004_030C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BAND_LSB = 3;
  localparam int BAND_MSB = 4;
  localparam int TRIM_LSB = 0;
  localparam int TRIM_MSB = 7;
  localparam int CTRL_FAST_ON = 0;
  localparam int CTRL_SRC_FAST = 1;
  localparam int CTRL_DIV_HALF = 2;
  localparam int CTRL_SLEEP = 3;
  localparam int CTRL_IDLE = 4;
  localparam int STAT_FAST_RDY = 0;
  localparam int STAT_SLOW_RDY = 1;
  localparam int STAT_CPU_FAST = 2;
  localparam int STAT_MODE_LSB = 4;
  localparam int STAT_MODE_MSB = 6;
  localparam int STAT_CAL_LSB = 8;
  localparam int STAT_CAL_MSB = 15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BAND_RESET = 2'h0;
  localparam logic [7:0] TRIM_RESET = 8'h80;
  localparam logic CTRL_FAST_ON_RESET = 1'b1;
  localparam logic CTRL_SRC_FAST_RESET = 1'b1;
  localparam logic CTRL_DIV_HALF_RESET = 1'b0;

  // Per-band factory trims, values arbitrary
  localparam logic [7:0] CAL_BAND0 = 8'h80;
  localparam logic [7:0] CAL_BAND1 = 8'h80;
  localparam logic [7:0] CAL_BAND2 = 8'h80;
  localparam logic [7:0] CAL_BAND3 = 8'h80;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FAST_SETTLE_NS = 500_000;
  localparam int SLOW_SETTLE_NS = 510_000;
  localparam int FAST_PERIOD_2M_NS = 500;
  localparam int SLOW_PERIOD_NS = 28_571;
  localparam int SLEEP_WAKE_FAST_CYC = 1024;
  localparam int SLEEP_WAKE_SLOW_CYC = 2048;
  localparam int SLEEP_WAKE_MAX_NS = 64_000_000;
  localparam int IDLE_WAKE_INSTR = 500;

  localparam int SLEEP_WAKE_NS = SLEEP_WAKE_FAST_CYC * FAST_PERIOD_2M_NS
                                 + SLEEP_WAKE_SLOW_CYC * SLOW_PERIOD_NS;
  localparam int FAST_SETTLE_CYC = (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_SETTLE_CYC = (SLOW_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_CYC = (SLEEP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_WAKE_MAX_CYC = SLEEP_WAKE_MAX_NS / CLK_PERIOD_NS;
  localparam int IDLE_WAKE_2M_CYC = IDLE_WAKE_INSTR * FAST_PERIOD_2M_NS / CLK_PERIOD_NS;
  localparam int IDLE_WAKE_SLOW_CYC = IDLE_WAKE_INSTR * SLOW_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE,
    MODE_IDLE,
    MODE_SLEEP,
    MODE_WAKE_IDLE,
    MODE_WAKE_SLEEP
  } oscpm_mode_type;

endpackage

// ==== hw/oscpm_sync.sv ====
// Two-stage synchroniser for an asynchronous level
`timescale 1ns/1ps
module oscpm_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Level
  input wire logic asyncIn,
  output logic syncOut
);

  logic meta_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= 1'b0;
      syncOut <= 1'b0;
    end else if (ce) begin
      meta_r <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

// ==== hw/oscpm_settle.sv ====
// Down counter that reports when a start-up or wake delay has expired
`timescale 1ns/1ps
module oscpm_settle (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic enable,
  input wire logic restart,
  input wire logic [31:0] loadCount,
  // Status
  output logic ready
);

  logic [31:0] cnt_r;

  // Disabled or restarted counters reload so each start waits the full time
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 32'h0000_0000;
    end else if (ce) begin
      if (!enable || restart) begin
        cnt_r <= loadCount;
      end else if (cnt_r != 32'h0000_0000) begin
        cnt_r <= cnt_r - 32'h0000_0001;
      end
    end
  end

  assign ready = enable & ~restart & (cnt_r == 32'h0000_0000);

endmodule

// ==== hw/oscpm_ctrl.sv ====
// Oscillator power mode controller: trim, band, settle and sleep/idle wake timing
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
module oscpm_ctrl #(
  parameter int FAST_SETTLE_CYC = oscpm_pkg::FAST_SETTLE_CYC,
  parameter int SLOW_SETTLE_CYC = oscpm_pkg::SLOW_SETTLE_CYC,
  parameter int SLEEP_WAKE_CYC = oscpm_pkg::SLEEP_WAKE_CYC,
  parameter int IDLE_WAKE_2M_CYC = oscpm_pkg::IDLE_WAKE_2M_CYC,
  parameter int IDLE_WAKE_SLOW_CYC = oscpm_pkg::IDLE_WAKE_SLOW_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Wake request pin
  input wire logic wakeReq,
  // Fast oscillator control
  output logic fastOscEn,
  output logic [1:0] fastOscBand,
  output logic [7:0] fastOscTrim,
  // Slow oscillator and watchdog
  output logic slowOscEn,
  output logic watchdogClkEn,
  // Processor clock and power state
  output logic cpuClkFast,
  output logic cpuClkDivHalf,
  output logic cpuStandby,
  output logic sleepState
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0] band_r;
  logic [7:0] trim_r;
  logic fastOn_r;
  logic srcFast_r;
  logic divHalf_r;
  logic bandChg_r;
  logic ack_r;
  logic [31:0] rdat_r;
  logic cpuFast_r;
  logic fastEn_r;
  logic slowEn_r;
  logic wakeStart_r;
  logic [31:0] wakeLoad_r;
  oscpm_pkg::oscpm_mode_type mode_r;
  logic wakeSync;
  logic fastReady;
  logic slowReady;
  logic wakeDone;
  logic busReq;
  logic busWr;
  logic wrCtrl;
  logic sleepCmd;
  logic idleCmd;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Factory trim for a band
  function automatic logic [7:0] calForBand(input logic [1:0] b);
    case (b)
      2'h0: calForBand = oscpm_pkg::CAL_BAND0;
      2'h1: calForBand = oscpm_pkg::CAL_BAND1;
      2'h2: calForBand = oscpm_pkg::CAL_BAND2;
      default: calForBand = oscpm_pkg::CAL_BAND3;
    endcase
  endfunction

  // Address match against one register
  function automatic logic hit(input logic [31:0] adr, input logic [31:0] reg_adr);
    hit = (adr[31:2] == reg_adr[31:2]);
  endfunction

  // Idle wake time: fixed instruction count at the current processor clock
  function automatic logic [31:0] idleWake(input logic onFast, input logic [1:0] b,
                                           input logic half);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (onFast) begin
      v = 32'(IDLE_WAKE_2M_CYC) >> b;
      if (half) begin
        v = v << 1;
      end
    end else begin
      v = 32'(IDLE_WAKE_SLOW_CYC);
    end
    idleWake = v;
  endfunction

  // ----------------------------------------------------------------
  // Wake pin synchroniser
  // ----------------------------------------------------------------
  oscpm_sync u_wakeSync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .asyncIn(wakeReq),
    .syncOut(wakeSync)
  );

  // ----------------------------------------------------------------
  // Settle and wake counters
  // ----------------------------------------------------------------
  // fast oscillator settle
  oscpm_settle u_fastSettle (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .enable(fastEn_r),
    .restart(bandChg_r),
    .loadCount(32'(FAST_SETTLE_CYC)),
    .ready(fastReady)
  );

  oscpm_settle u_slowSettle (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .enable(slowEn_r),
    .restart(1'b0),
    .loadCount(32'(SLOW_SETTLE_CYC)),
    .ready(slowReady)
  );

  oscpm_settle u_wakeTimer (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .enable(mode_r == oscpm_pkg::MODE_WAKE_IDLE || mode_r == oscpm_pkg::MODE_WAKE_SLEEP),
    .restart(wakeStart_r),
    .loadCount(wakeLoad_r),
    .ready(wakeDone)
  );

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state; ack drops the cycle after it was given
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_r;
  assign busWr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  assign wrCtrl = busWr & wb_sel_i[0] & hit(wb_adr_i, oscpm_pkg::ADR_CTRL);
  assign sleepCmd = wrCtrl & wb_dat_i[oscpm_pkg::CTRL_SLEEP];
  assign idleCmd = wrCtrl & wb_dat_i[oscpm_pkg::CTRL_IDLE];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= busReq;
    end
  end

  // Unmapped addresses still ack, reading zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdat_r <= 32'h0000_0000;
    end else if (ce && busReq) begin
      rdat_r <= 32'h0000_0000;
      if (hit(wb_adr_i, oscpm_pkg::ADR_BAND)) begin
        rdat_r[oscpm_pkg::BAND_MSB:oscpm_pkg::BAND_LSB] <= band_r;
      end else if (hit(wb_adr_i, oscpm_pkg::ADR_TRIM)) begin
        rdat_r[oscpm_pkg::TRIM_MSB:oscpm_pkg::TRIM_LSB] <= trim_r;
      end else if (hit(wb_adr_i, oscpm_pkg::ADR_CTRL)) begin
        rdat_r[oscpm_pkg::CTRL_FAST_ON] <= fastOn_r;
        rdat_r[oscpm_pkg::CTRL_SRC_FAST] <= srcFast_r;
        rdat_r[oscpm_pkg::CTRL_DIV_HALF] <= divHalf_r;
      end else if (hit(wb_adr_i, oscpm_pkg::ADR_STAT)) begin
        rdat_r[oscpm_pkg::STAT_FAST_RDY] <= fastReady;
        rdat_r[oscpm_pkg::STAT_SLOW_RDY] <= slowReady;
        rdat_r[oscpm_pkg::STAT_CPU_FAST] <= cpuFast_r;
        rdat_r[oscpm_pkg::STAT_MODE_MSB:oscpm_pkg::STAT_MODE_LSB] <= mode_r;
        rdat_r[oscpm_pkg::STAT_CAL_MSB:oscpm_pkg::STAT_CAL_LSB] <= calForBand(band_r);
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------
  // Band and trim registers
  // ----------------------------------------------------------------
  // band select, 2 MHz after reset; a change restarts the settle count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      band_r <= oscpm_pkg::BAND_RESET;
      bandChg_r <= 1'b0;
    end else if (ce) begin
      bandChg_r <= 1'b0;
      if (busWr && wb_sel_i[0] && hit(wb_adr_i, oscpm_pkg::ADR_BAND)) begin
        band_r <= wb_dat_i[oscpm_pkg::BAND_MSB:oscpm_pkg::BAND_LSB];
        bandChg_r <= (wb_dat_i[oscpm_pkg::BAND_MSB:oscpm_pkg::BAND_LSB] != band_r);
      end
    end
  end

  // trim passes straight to the oscillator
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trim_r <= oscpm_pkg::TRIM_RESET;
    end else if (ce && busWr && wb_sel_i[0] && hit(wb_adr_i, oscpm_pkg::ADR_TRIM)) begin
      trim_r <= wb_dat_i[oscpm_pkg::TRIM_MSB:oscpm_pkg::TRIM_LSB];
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fastOn_r <= oscpm_pkg::CTRL_FAST_ON_RESET;
      srcFast_r <= oscpm_pkg::CTRL_SRC_FAST_RESET;
      divHalf_r <= oscpm_pkg::CTRL_DIV_HALF_RESET;
    end else if (ce) begin
      if (mode_r == oscpm_pkg::MODE_SLEEP && wakeSync) begin
        // wake from sleep restarts the fast oscillator too
        fastOn_r <= 1'b1;
      end else if (wrCtrl) begin
        fastOn_r <= wb_dat_i[oscpm_pkg::CTRL_FAST_ON];
        srcFast_r <= wb_dat_i[oscpm_pkg::CTRL_SRC_FAST];
        divHalf_r <= wb_dat_i[oscpm_pkg::CTRL_DIV_HALF];
      end
    end
  end

  // ----------------------------------------------------------------
  // Power mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= oscpm_pkg::MODE_ACTIVE;
      wakeStart_r <= 1'b0;
      wakeLoad_r <= 32'h0000_0000;
    end else if (ce) begin
      wakeStart_r <= 1'b0;
      case (mode_r)
        oscpm_pkg::MODE_ACTIVE: begin
          // Sleep takes priority when both commands are written together
          if (sleepCmd) begin
            mode_r <= oscpm_pkg::MODE_SLEEP;
          end else if (idleCmd) begin
            mode_r <= oscpm_pkg::MODE_IDLE;
          end
        end
        oscpm_pkg::MODE_IDLE: begin
          // idle wake length follows the processor clock
          if (wakeSync) begin
            mode_r <= oscpm_pkg::MODE_WAKE_IDLE;
            wakeStart_r <= 1'b1;
            wakeLoad_r <= idleWake(cpuFast_r, band_r, divHalf_r);
          end
        end
        oscpm_pkg::MODE_SLEEP: begin
          // fixed fast plus slow cycle wake delay
          if (wakeSync) begin
            mode_r <= oscpm_pkg::MODE_WAKE_SLEEP;
            wakeStart_r <= 1'b1;
            wakeLoad_r <= 32'(SLEEP_WAKE_CYC);
          end
        end
        oscpm_pkg::MODE_WAKE_IDLE, oscpm_pkg::MODE_WAKE_SLEEP: begin
          if (wakeDone) begin
            mode_r <= oscpm_pkg::MODE_ACTIVE;
          end
        end
        default: begin
          mode_r <= oscpm_pkg::MODE_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fastEn_r <= 1'b0;
      slowEn_r <= 1'b0;
    end else if (ce) begin
      // sleep stops every band; idle leaves the fast oscillator alone
      fastEn_r <= fastOn_r && mode_r != oscpm_pkg::MODE_SLEEP && !(mode_r == oscpm_pkg::MODE_ACTIVE && sleepCmd);
      // sleep stops the slow oscillator; idle keeps it; no software off
      slowEn_r <= mode_r != oscpm_pkg::MODE_SLEEP && !(mode_r == oscpm_pkg::MODE_ACTIVE && sleepCmd);
    end
  end

  // ----------------------------------------------------------------
  // Processor clock select
  // ----------------------------------------------------------------
  // hold the old source until the requested one has settled; with the fast oscillator off, drop to slow at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpuFast_r <= 1'b0;
    end else if (ce) begin
      if (!fastEn_r) begin
        cpuFast_r <= 1'b0;
      end else if (srcFast_r && fastReady) begin
        cpuFast_r <= 1'b1;
      end else if (!srcFast_r && slowReady) begin
        cpuFast_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign fastOscEn = fastEn_r;
  assign fastOscBand = band_r;
  assign fastOscTrim = trim_r;
  assign slowOscEn = slowEn_r;
  // watchdog runs only from a stable slow oscillator
  assign watchdogClkEn = slowEn_r & slowReady;
  assign cpuClkFast = cpuFast_r;
  assign cpuClkDivHalf = divHalf_r;
  assign cpuStandby = (mode_r != oscpm_pkg::MODE_ACTIVE);
  assign sleepState = (mode_r == oscpm_pkg::MODE_SLEEP);

endmodule

// ==== verification/oscpm_ctrl_props.sv ====
// Port checker for the oscillator power mode controller
`timescale 1ns/1ps
module oscpm_ctrl_props #(
  parameter int FAST_SETTLE_CYC = 20,
  parameter int SLEEP_WAKE_CYC = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_ack_o,
  // Oscillators and power state
  input wire logic fastOscEn,
  input wire logic [1:0] fastOscBand,
  input wire logic [7:0] fastOscTrim,
  input wire logic slowOscEn,
  input wire logic watchdogClkEn,
  input wire logic cpuClkFast,
  input wire logic cpuStandby,
  input wire logic sleepState
);
  // Wake overhead beyond the count is a few cycles of sync and state
  localparam int SW_LO = SLEEP_WAKE_CYC - 2;
  localparam int SW_HI = SLEEP_WAKE_CYC + 6;
  logic [31:0] fastOnCnt_r;
  logic [1:0] bandPrev_r;
  logic wrLane0;
  assign wrLane0 = wb_ack_o && wb_we_i && wb_sel_i[0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------------
  // Run time of the fast oscillator on its present band
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fastOnCnt_r <= 32'h0000_0000;
      bandPrev_r <= 2'h0;
    end else begin
      bandPrev_r <= fastOscBand;
      fastOnCnt_r <= (!fastOscEn || fastOscBand != bandPrev_r) ? 32'h0000_0000 : fastOnCnt_r + 32'h0000_0001;
    end
  end

  sequence sWakeDone;
    ##[SW_LO:SW_HI] $fell(cpuStandby);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_one_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle pulse");
  a_trim_by_write: assert property ($changed(fastOscTrim) |-> $past(wrLane0 && wb_adr_i[31:2] == oscpm_pkg::ADR_TRIM[31:2]))
    else $error("trim changed without a trim write");
  a_band_by_write: assert property ($changed(fastOscBand) |-> $past(wrLane0 && wb_adr_i[31:2] == oscpm_pkg::ADR_BAND[31:2]))
    else $error("band changed without a band write");
  a_sleep_fast_off: assert property (sleepState |-> !fastOscEn)
    else $error("fast oscillator running in sleep");
  a_sleep_slow_off: assert property (sleepState |-> !slowOscEn)
    else $error("slow oscillator running in sleep");
  a_slow_kept_on: assert property (!sleepState && $past(slowOscEn) |-> slowOscEn)
    else $error("slow oscillator stopped outside sleep");
  a_idle_fast_run: assert property ($rose(cpuStandby) && !sleepState |-> fastOscEn == $past(fastOscEn))
    else $error("idle entry changed the fast oscillator");
  a_idle_slow_run: assert property (cpuStandby && !sleepState && !$past(sleepState) |-> slowOscEn)
    else $error("slow oscillator stopped in idle");
  a_watchdog_slow_settled: assert property ($rose(watchdogClkEn) |-> slowOscEn && $past(slowOscEn, 8))
    else $error("watchdog clock before slow oscillator settled");
  a_cpu_fast_settled: assert property ($rose(cpuClkFast) |-> fastOscEn && fastOnCnt_r >= FAST_SETTLE_CYC - 2)
    else $error("processor moved to fast clock before settle");
  a_sleep_wake_time: assert property ($fell(sleepState) |-> sWakeDone)
    else $error("sleep wake time out of range");
endmodule

// ==== verification/testbench.sv ====
// Self-checking testbench for the oscillator power mode controller
`timescale 1ns/1ps
module testbench;
  localparam int FAST_C = 20;
  localparam int SLEEP_C = 40;
  localparam int IDLE_C = 32;
  logic clk, rst_b, ce, wbCyc, wbStb, wbWe, wbAck, wakeReq;
  logic [31:0] wbAdr, wbDatI, wbDatO, seed, d;
  logic [3:0] wbSel;
  logic fastOscEn, slowOscEn, watchdogClkEn, cpuClkFast, cpuClkDivHalf, cpuStandby, sleepState;
  logic [1:0] fastOscBand;
  logic [7:0] fastOscTrim;
  logic [7:0] cal [4];
  logic [31:0] expQ [$];
  int errTotal, comparisons, cyc, n;

  oscpm_ctrl #(.FAST_SETTLE_CYC(FAST_C), .SLOW_SETTLE_CYC(25), .SLEEP_WAKE_CYC(SLEEP_C),
    .IDLE_WAKE_2M_CYC(IDLE_C), .IDLE_WAKE_SLOW_CYC(30)) dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .wakeReq(wakeReq), .fastOscEn(fastOscEn), .fastOscBand(fastOscBand), .fastOscTrim(fastOscTrim),
    .slowOscEn(slowOscEn), .watchdogClkEn(watchdogClkEn), .cpuClkFast(cpuClkFast),
    .cpuClkDivHalf(cpuClkDivHalf), .cpuStandby(cpuStandby), .sleepState(sleepState));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic stopTest;
    $display("Comparisons %0d, mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Single classic cycle; a read notes its expected word first
  task automatic wbXfer(input logic we, input logic [31:0] adr, input logic [31:0] dat);
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    if (!we) begin
      expQ.push_back(dat);
    end
    // No local limit: only the bench timeout ends a missing answer
    @(posedge clk);
    while (wbAck !== 1'b1) begin
      @(posedge clk);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    // Extra edge lets the write land before callers look at ports
    @(posedge clk);
  endtask

  task automatic waitFor(ref logic sig, input logic lvl, output int cnt);
    cnt = 0;
    while (sig !== lvl) begin
      @(posedge clk);
      cnt++;
    end
  endtask

  // Read answers matched against the oldest note
  always @(posedge clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
      chk(wbDatO, expQ.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errTotal++;
      stopTest();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h8215_c1da;
    cal = '{oscpm_pkg::CAL_BAND0, oscpm_pkg::CAL_BAND1, oscpm_pkg::CAL_BAND2, oscpm_pkg::CAL_BAND3};
    {rst_b, wbCyc, wbStb, wbWe, wakeReq} = 5'h00;
    ce = 1'b1;
    wbSel = 4'hf;
    wbAdr = 32'h0000_0000;
    wbDatI = 32'h0000_0000;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(fastOscTrim, oscpm_pkg::TRIM_RESET);
    wbXfer(1'b0, oscpm_pkg::ADR_TRIM, 32'(oscpm_pkg::TRIM_RESET));
    wbXfer(1'b0, oscpm_pkg::ADR_BAND, 32'(oscpm_pkg::BAND_RESET) << 3);
    waitFor(cpuClkFast, 1'b1, n);
    chk(cpuClkFast, 1'b1);
    waitFor(watchdogClkEn, 1'b1, n);
    chk(slowOscEn, 1'b1);
    wbXfer(1'b0, oscpm_pkg::ADR_STAT, {16'h0000, oscpm_pkg::CAL_BAND0, 8'h07});
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      wbXfer(1'b1, oscpm_pkg::ADR_TRIM, d);
      wbXfer(1'b0, oscpm_pkg::ADR_TRIM, {24'h00_0000, d[7:0]});
      chk(fastOscTrim, d[7:0]);
    end
    for (int b = 0; b < 4; b++) begin
      wbXfer(1'b1, oscpm_pkg::ADR_BAND, 32'(b) << 3);
      wbXfer(1'b1, oscpm_pkg::ADR_TRIM, 32'(cal[b]));
      wbXfer(1'b0, oscpm_pkg::ADR_BAND, 32'(b) << 3);
      chk(fastOscBand, 32'(b));
      chk(fastOscTrim, cal[b]);
    end
    wbXfer(1'b1, oscpm_pkg::ADR_CTRL, 32'h0000_0007);
    chk(cpuClkDivHalf, 1'b1);
    wbXfer(1'b1, oscpm_pkg::ADR_BAND, 32'h0000_0000);
    wbXfer(1'b1, oscpm_pkg::ADR_TRIM, 32'(cal[0]));
    wbXfer(1'b1, oscpm_pkg::ADR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(fastOscEn, 1'b0);
    chk(cpuClkFast, 1'b0);
    chk(slowOscEn, 1'b1);
    wbXfer(1'b0, oscpm_pkg::ADR_CTRL, 32'h0000_0000);
    wbXfer(1'b1, 32'h0004_0310, 32'hffff_ffff);
    wbXfer(1'b0, 32'h0004_0310, 32'h0000_0000);
    wbXfer(1'b1, oscpm_pkg::ADR_CTRL, 32'h0000_0003);
    waitFor(cpuClkFast, 1'b1, n);
    // Halved processor clock doubles the idle wake count
    wbXfer(1'b1, oscpm_pkg::ADR_CTRL, 32'h0000_0017);
    repeat (2) @(posedge clk);
    chk({cpuStandby, sleepState, fastOscEn}, 32'h0000_0005);
    chk(slowOscEn, 1'b1);
    wakeReq <= 1'b1;
    waitFor(cpuStandby, 1'b0, n);
    wakeReq <= 1'b0;
    chk(32'(n >= 2 * IDLE_C && n <= 2 * IDLE_C + 8), 32'h0000_0001);
    waitFor(cpuClkFast, 1'b1, n);
    wbXfer(1'b1, oscpm_pkg::ADR_CTRL, 32'h0000_000b);
    repeat (2) @(posedge clk);
    chk({sleepState, fastOscEn}, 32'h0000_0002);
    chk({slowOscEn, watchdogClkEn}, 32'h0000_0000);
    wakeReq <= 1'b1;
    waitFor(cpuStandby, 1'b0, n);
    wakeReq <= 1'b0;
    chk(32'(n >= SLEEP_C && n <= SLEEP_C + 10), 32'h0000_0001);
    chk(slowOscEn, 1'b1);
    repeat (4) @(posedge clk);
    stopTest();
  end
endmodule

bind oscpm_ctrl oscpm_ctrl_props #(.FAST_SETTLE_CYC(FAST_SETTLE_CYC), .SLEEP_WAKE_CYC(SLEEP_WAKE_CYC)) props (
  .clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o), .fastOscEn(fastOscEn),
  .fastOscBand(fastOscBand), .fastOscTrim(fastOscTrim), .slowOscEn(slowOscEn),
  .watchdogClkEn(watchdogClkEn), .cpuClkFast(cpuClkFast), .cpuStandby(cpuStandby), .sleepState(sleepState));
